// ---- rtl/scs_channel_status.sv ----
// Channel status register bank with command interlock, reachable over APB.
//
// Behaviour
// - Writing more than 32 bytes into transmit FIFO sets overflow flag.
// - Overflow clears on transmit reset command or when accessible half drains.
// - Receive nonempty flag follows whether accessible receive half holds bytes.
// - Reacquire command clears the sync flag; receiver hunts for SYN.
// - SYN found while hunting sets sync, raises enabled interrupt, starts filling.
// - Command executing flag reads zero when no command runs.
// - Host must not write a command while executing flag is one.
// - Executing flag lasts at most 2.5 transmit clock periods outside power-down.
// - In power-down the executing flag stays asserted.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module scs_channel_status (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Channel events
	input wire logic TX_BYTE_WRITE,
	input wire logic TX_HALF_MOVED,
	input wire logic RX_NONEMPTY_IN,
	input wire logic SYN_MATCH,
	input wire logic TX_CLK_EDGE,
	input wire logic CTS_IN,
	// Channel controls
	output logic SYN_FOUND_IRQ,
	output logic RX_FILL_EN,
	output logic TX_RESET_PULSE
);
	scs_fifo_if fif ();
	scs_pkg::scs_cmd_state_e cmd_state_q;
	logic [7:0] command_reg_q;
	logic [7:0] ctrl_q;
	logic [3:0] half_cnt_q;
	logic sync_q;
	logic hunting_q;
	logic rx_ne_q;
	logic cts_q;
	logic [7:0] status;
	logic access;
	logic wr_cmd;
	logic wr_ctrl;
	logic mapped;

	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : is_reg

	assign access = PSEL && PENABLE && CE;
	// Command writes while busy are dropped; the host is expected to poll first.
	assign wr_cmd = access && PWRITE && is_reg(PADDR, scs_pkg::STATUS_OFFSET) &&
		(cmd_state_q == scs_pkg::CS_IDLE);
	assign wr_ctrl = access && PWRITE && is_reg(PADDR, scs_pkg::CTRL_OFFSET);
	assign mapped = is_reg(PADDR, scs_pkg::STATUS_OFFSET) || is_reg(PADDR, scs_pkg::CTRL_OFFSET);

	assign fif.push = TX_BYTE_WRITE;
	assign fif.drain = TX_HALF_MOVED;
	assign fif.flush = wr_cmd && |(PWDATA[7:0] & scs_pkg::CMD_TX_RESET);

	scs_tx_tracker #(
		.DEPTH(scs_pkg::FIFO_HALF_BYTES)
	) u_tracker (
		.clk(CLK),
		.rst(SYS_RST),
		.ce(CE),
		.fif(fif)
	);

	always_comb begin
		status = 8'h00;
		status[scs_pkg::BIT_TX_OVERFLOW] = fif.overflow;
		status[scs_pkg::BIT_TX_WRITABLE] = fif.writable;
		status[scs_pkg::BIT_RX_NONEMPTY] = rx_ne_q;
		status[scs_pkg::BIT_SYNC] = sync_q;
		status[scs_pkg::BIT_CMD_EXEC] = (cmd_state_q != scs_pkg::CS_IDLE);
		status[scs_pkg::BIT_CTS] = cts_q;
	end

	// APB: zero wait states, unmapped addresses answer with an error.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped;
			if (PSEL && !PENABLE && !PWRITE) begin
				if (is_reg(PADDR, scs_pkg::STATUS_OFFSET)) begin
					PRDATA <= {24'h00_0000, status};
				end else if (is_reg(PADDR, scs_pkg::CTRL_OFFSET)) begin
					PRDATA <= {24'h00_0000, ctrl_q};
				end else begin
					PRDATA <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_q <= 8'h00;
		end else if (wr_ctrl) begin
			ctrl_q <= PWDATA[7:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			command_reg_q <= 8'h00;
		end else if (wr_cmd) begin
			command_reg_q <= PWDATA[7:0];
		end
	end

	// Busy is counted in half transmit clock periods, so five edges bound it at 2.5 periods.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cmd_state_q <= scs_pkg::CS_IDLE;
			half_cnt_q <= 4'h0;
		end else if (CE) begin
			case (cmd_state_q)
				scs_pkg::CS_IDLE: begin
					if (wr_cmd) begin
						cmd_state_q <= ctrl_q[scs_pkg::CTRL_BIT_POWER_DOWN] ? scs_pkg::CS_HOLD : scs_pkg::CS_RUN;
						half_cnt_q <= 4'h0;
					end
				end
				scs_pkg::CS_RUN: begin
					if (ctrl_q[scs_pkg::CTRL_BIT_POWER_DOWN]) begin
						cmd_state_q <= scs_pkg::CS_HOLD;
					end else if (TX_CLK_EDGE) begin
						if (half_cnt_q >= 4'(scs_pkg::BUSY_LIMIT_HALF_PERIODS - 1)) begin
							cmd_state_q <= scs_pkg::CS_IDLE;
						end else begin
							half_cnt_q <= half_cnt_q + 4'h1;
						end
					end
				end
				scs_pkg::CS_HOLD: begin
					if (!ctrl_q[scs_pkg::CTRL_BIT_POWER_DOWN]) begin
						cmd_state_q <= scs_pkg::CS_RUN;
						half_cnt_q <= 4'h0;
					end
				end
				default: begin
					cmd_state_q <= scs_pkg::CS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sync_q <= 1'b0;
			hunting_q <= 1'b0;
			SYN_FOUND_IRQ <= 1'b0;
			RX_FILL_EN <= 1'b0;
		end else if (CE) begin
			SYN_FOUND_IRQ <= 1'b0;
			if (wr_cmd && |(PWDATA[7:0] & scs_pkg::CMD_REACQUIRE)) begin
				sync_q <= 1'b0;
				hunting_q <= 1'b1;
				RX_FILL_EN <= 1'b0;
			end else if (hunting_q && SYN_MATCH) begin
				sync_q <= 1'b1;
				hunting_q <= 1'b0;
				RX_FILL_EN <= 1'b1;
				SYN_FOUND_IRQ <= ctrl_q[scs_pkg::CTRL_BIT_SYN_IRQ_EN];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rx_ne_q <= 1'b0;
			cts_q <= 1'b0;
			TX_RESET_PULSE <= 1'b0;
		end else if (CE) begin
			rx_ne_q <= RX_NONEMPTY_IN;
			cts_q <= CTS_IN;
			TX_RESET_PULSE <= fif.flush;
		end
	end
endmodule : scs_channel_status

// ---- rtl/scs_pkg.sv ----
// Package with the status register map, field positions and timing constants.
package scs_pkg;
	localparam logic [7:0] STATUS_OFFSET = 8'h20;
	localparam logic [7:0] CTRL_OFFSET = 8'h24;
	localparam logic [7:0] STATUS_RESET = 8'h40;
	localparam int BIT_TX_OVERFLOW = 7;
	localparam int BIT_TX_WRITABLE = 6;
	localparam int BIT_RX_NONEMPTY = 5;
	localparam int BIT_SYNC = 4;
	localparam int BIT_CMD_EXEC = 2;
	localparam int BIT_CTS = 1;
	localparam int CTRL_BIT_POWER_DOWN = 0;
	localparam int CTRL_BIT_SYN_IRQ_EN = 1;
	localparam int FIFO_HALF_BYTES = 32;
	localparam int BUSY_LIMIT_HALF_PERIODS = 5;
	localparam logic [7:0] CMD_TX_RESET = 8'h01;
	localparam logic [7:0] CMD_REACQUIRE = 8'h04;
	typedef enum logic [1:0] {CS_IDLE, CS_RUN, CS_HOLD} scs_cmd_state_e;
endpackage : scs_pkg

// ---- rtl/scs_fifo_if.sv ----
// Interface carrying transmit FIFO fill events between the top and the fill tracker.
`timescale 1ns/10ps
interface scs_fifo_if;
	logic push;
	logic drain;
	logic flush;
	logic overflow;
	logic writable;
	modport tracker (input push, input drain, input flush, output overflow, output writable);
	modport owner (output push, output drain, output flush, input overflow, input writable);
endinterface : scs_fifo_if

// ---- rtl/scs_tx_tracker.sv ----
// Transmit FIFO accessible-half fill tracker with overflow flag.
`timescale 1ns/10ps
module scs_tx_tracker #(
	parameter int DEPTH = scs_pkg::FIFO_HALF_BYTES
) (
	// Clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Events
	scs_fifo_if.tracker fif
);
	logic [6:0] count_q;
	logic ovf_q;
	always_ff @(posedge clk) begin
		if (rst || fif.flush) begin
			count_q <= 7'h00;
		end else if (ce) begin
			if (fif.drain) begin
				count_q <= 7'h00;
			end else if (fif.push && count_q <= 7'(DEPTH)) begin
				count_q <= count_q + 7'h01;
			end
		end
	end
	// Set wins over a simultaneous drain so the overflowing write is not lost.
	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_q <= 1'b0;
		end else if (ce) begin
			if (fif.push && count_q >= 7'(DEPTH)) begin
				ovf_q <= 1'b1;
			end else if (fif.flush || fif.drain) begin
				ovf_q <= 1'b0;
			end
		end
	end
	assign fif.overflow = ovf_q;
	assign fif.writable = (count_q < 7'(DEPTH));
endmodule : scs_tx_tracker

// ---- bench/scs_chk.sv ----
// Port checker for the status block.
`timescale 1ns/10ps
module scs_chk (
	// Watched ports
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SYN_MATCH,
	input wire logic SYN_FOUND_IRQ,
	input wire logic RX_FILL_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence setup_s; PSEL && !PENABLE && CE; endsequence
	sequence stat_s; PREADY && !PWRITE && PADDR == 8'h20; endsequence
	ready_next_a: assert property (setup_s |=> PREADY) else $error("ready late");
	ready_once_a: assert property (PREADY |=> !PREADY) else $error("ready held");
	ready_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
	err_ready_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
	err_unmapped_a: assert property (PREADY && PADDR != 8'h20 && PADDR != 8'h24 |-> PSLVERR) else $error("no error");
	spare_zero_a: assert property (stat_s |-> !PRDATA[3] && !PRDATA[0]) else $error("spare set");
	irq_pulse_a: assert property (SYN_FOUND_IRQ |=> !SYN_FOUND_IRQ) else $error("irq held");
	irq_cause_a: assert property (SYN_FOUND_IRQ |-> $past(SYN_MATCH)) else $error("stray irq");
	fill_on_a: assert property (SYN_FOUND_IRQ |-> RX_FILL_EN) else $error("no fill");
endmodule : scs_chk
bind scs_channel_status scs_chk chk (.*);

// ---- bench/scs_host.sv ----
// Host bus master model for the status block.
`timescale 1ns/10ps
module scs_host (
	// Bus
	input wire logic clk,
	input wire logic ready,
	input wire logic [31:0] rdata,
	output logic sel,
	output logic en,
	output logic wr,
	output logic [7:0] addr,
	output logic [31:0] wdata
);
	initial {sel, en, wr, addr, wdata} = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		{sel, wr, addr, wdata} <= {1'h1, w, a, d};
		@(posedge clk);
		en <= 1'h1;
		@(posedge clk);
		while (ready !== 1'h1) @(posedge clk);
		q = rdata;
		{sel, en} <= 2'h0;
		@(posedge clk);
	endtask : xfer
	// A command written while busy is lost, so the host polls first.
	task automatic cmd(input logic [31:0] d);
		logic [31:0] q;
		q = 32'h4;
		while (q[2] !== 1'h0) xfer(1'h0, 8'h20, 32'h0, q);
		xfer(1'h1, 8'h20, d, q);
	endtask : cmd
endmodule : scs_host

// ---- bench/test_serial_channel_status_register.sv ----
// Self-checking bench for the status block.
`timescale 1ns/10ps
module test_serial_channel_status_register;
	logic CLK = 1'h0, SYS_RST = 1'h1, CE = 1'h1, TX_BYTE_WRITE = 1'h0, TX_HALF_MOVED = 1'h0;
	logic RX_NONEMPTY_IN = 1'h0, SYN_MATCH = 1'h0, CTS_IN = 1'h0, TX_CLK_EDGE = 1'h0;
	logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SYN_FOUND_IRQ, RX_FILL_EN, TX_RESET_PULSE;
	logic [1:0] ph = 2'h0;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, r;
	logic [9:0] rows [4] = '{10'h040, 10'h142, 10'h260, 10'h362};
	int mismatches = 0, comparisons = 0;
	always #25 CLK = ~CLK;
	// A fast transmit clock keeps each command short.
	always @(posedge CLK) begin
		ph <= ph + 2'h1;
		TX_CLK_EDGE <= ph == 2'h3;
	end
	scs_channel_status DUT (.*);
	scs_host host (.clk(CLK), .ready(PREADY), .rdata(PRDATA), .sel(PSEL), .en(PENABLE), .wr(PWRITE),
		.addr(PADDR), .wdata(PWDATA));
	task check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, seen, want);
		end
	endtask : check
	task wt(input int n);
		repeat (n) @(posedge CLK);
	endtask : wt
	task st(input logic [31:0] m, input logic [31:0] e);
		host.xfer(1'h0, 8'h20, 32'h0, r);
		check(r & m, e);
	endtask : st
	task bw(input int n);
		TX_BYTE_WRITE <= 1'h1;
		wt(n);
		TX_BYTE_WRITE <= 1'h0;
	endtask : bw
	task results;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		wt(2);
		SYS_RST <= 1'h0;
		st(32'hffffffff, 32'h40);
		host.xfer(1'h0, 8'h30, 32'h0, r);
		check(r, 32'h0);
		foreach (rows[i]) begin
			{RX_NONEMPTY_IN, CTS_IN} <= rows[i][9:8];
			wt(2);
			st(32'hff, {24'h0, rows[i][7:0]});
		end
		// While the enable is low, byte writes must not reach the fill count.
		CE <= 1'h0;
		bw(40);
		CE <= 1'h1;
		st(32'hc0, 32'h40);
		bw(32);
		st(32'hc0, 32'h0);
		bw(1);
		st(32'hc0, 32'h80);
		TX_HALF_MOVED <= 1'h1;
		wt(1);
		TX_HALF_MOVED <= 1'h0;
		st(32'hc0, 32'h40);
		bw(33);
		host.cmd(32'h1);
		check({31'h0, TX_RESET_PULSE}, 32'h1);
		st(32'hc4, 32'h44);
		wt(20);
		st(32'h4, 32'h0);
		host.xfer(1'h1, 8'h24, 32'h1, r);
		host.cmd(32'h1);
		wt(40);
		st(32'h4, 32'h4);
		host.xfer(1'h1, 8'h24, 32'h2, r);
		host.cmd(32'h4);
		st(32'h14, 32'h4);
		SYN_MATCH <= 1'h1;
		wt(1);
		SYN_MATCH <= 1'h0;
		wt(1);
		check({31'h0, RX_FILL_EN}, 32'h1);
		check({31'h0, SYN_FOUND_IRQ}, 32'h1);
		st(32'h10, 32'h10);
		host.cmd(32'h4);
		st(32'h10, 32'h0);
		// A second reset in mid-run must bring back the reset value.
		SYS_RST <= 1'h1;
		{RX_NONEMPTY_IN, CTS_IN} <= 2'h0;
		wt(2);
		SYS_RST <= 1'h0;
		st(32'hff, 32'h40);
		results();
	end
	initial begin
		wt(3000);
		mismatches++;
		results();
	end
endmodule : test_serial_channel_status_register
